// ---- verilog/mrsc_params.svh ----
// Constants for the reset source controller: register offsets, field positions, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MRSC_PARAMS_SVH
`define MRSC_PARAMS_SVH

`define MRSC_ADDR_STATUS_FIRST   4'h0
`define MRSC_ADDR_STATUS_SECOND  4'h1
`define MRSC_ADDR_STATUS_THIRD   4'h2
`define MRSC_ADDR_CONTROL        4'h3
`define MRSC_ADDR_ENABLE         4'h4
`define MRSC_ADDR_LIVE           4'h5

// reset_status_first fields
`define MRSC_BIT_POR             0
`define MRSC_BIT_VM0             1
`define MRSC_BIT_VM1             2
`define MRSC_BIT_VM2             3
// reset_status_second fields
`define MRSC_BIT_INDEPENDENT_WATCHDOG            0
`define MRSC_BIT_WDT             1
`define MRSC_BIT_SWR             2
`define MRSC_BIT_PAR             3
`define MRSC_BIT_ECC             4
`define MRSC_BIT_BMPU            5
`define MRSC_BIT_BSPU            6
`define MRSC_BIT_SPE             7
// reset_status_third fields
`define MRSC_BIT_COLD_WARM_START_FLAG            0
// control fields
`define MRSC_BIT_EXTCLK          0
`define MRSC_BIT_OSCSTOP         1
`define MRSC_BIT_SWREQ           2

`define MRSC_ENABLE_RESET        16'h03_FF
`define MRSC_CONTROL_RESET       8'h02

// Hold times in microseconds and the clock rate in MHz
`define MRSC_CLK_MHZ             100
`define MRSC_POR_HOLD_US         1000
`define MRSC_SW_HOLD_US          10
`define MRSC_POR_HOLD_CYC        (`MRSC_POR_HOLD_US * `MRSC_CLK_MHZ)
`define MRSC_SW_HOLD_CYC         (`MRSC_SW_HOLD_US * `MRSC_CLK_MHZ)

`endif

// ---- verilog/mrsc_pkg.sv ----
// Types for the reset source controller.
// Assumes the params header is on the include path.
package mrsc_pkg;
  `include "mrsc_params.svh"

  typedef enum logic [1:0] {
    MRSC_POR_HOLD = 2'b00,
    MRSC_RUN      = 2'b01,
    MRSC_SW_HOLD  = 2'b10
  } mrsc_state_t;
endpackage

// ---- verilog/mrsc_sync.sv ----
// Three-stage synchroniser bank with agreement filter for asynchronous inputs.
// Assumes one clock; output changes when stages two and three agree.
`timescale 1ns/1ps
module mrsc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!nrst) begin
          stage1[i]   <= INIT[i];
          stage2[i]   <= INIT[i];
          stage3[i]   <= INIT[i];
          sync_out[i] <= INIT[i];
        end else begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          if (stage2[i] == stage3[i]) begin
            sync_out[i] <= stage3[i];
          end
        end
      end
    end
  endgenerate
endmodule // mrsc_sync

// ---- verilog/mrsc_reset_ctrl.sv ----
// Reset generation and reset-cause capture for a small microcontroller.
// Assumes fault detectors and the pin are asynchronous; the register port runs on clk.
// nrst is the raw cell reset and clears everything power-on clears, plus the synchronisers and read data.
//
// Overview of operation
// - Low reset pin holds internal reset for as long as it stays low.
// - Either watchdog underflow or refresh violation raises internal reset.
// - Each of three supply monitors raises its own reset on low supply.
// - SRAM parity error and SRAM ECC error raise separate resets.
// - Bus master and bus slave protection errors raise separate resets.
// - Stack pointer error raises a reset.
// - Power-on reset holds until supply good plus fixed hold time.
// - Supply at or below threshold with pin high re-enters power-on reset.
// - Power-on sets the power-on cause flag; pin reset clears it.
// - External clock select bit makes oscillator take digital clock, crystal pin floats.
// - Software request bit raises reset released after fixed hold time.
// - Independent watchdog reset sets its cause flag; interrupt may replace reset.
// - Voltage monitor reset n sets matching cause flag.
// - Cold/warm flag clears on power-on only; software writes one to set.
`timescale 1ns/1ps
`include "mrsc_params.svh"
module mrsc_reset_ctrl
  import mrsc_pkg::*;
#(
  parameter int POR_HOLD_CYC = `MRSC_POR_HOLD_CYC,
  parameter int SW_HOLD_CYC  = `MRSC_SW_HOLD_CYC
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ext_reset_n,
  input  wire logic       supply_above_por,
  input  wire logic [2:0] monitor_low,
  input  wire logic       independent_watchdog_fault,
  input  wire logic       wdt_fault,
  input  wire logic       sram_parity_err,
  input  wire logic       sram_ecc_err,
  input  wire logic       bus_master_mpu_err,
  input  wire logic       bus_slave_mpu_err,
  input  wire logic       stack_ptr_err,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            sys_reset_n,
  output logic            independent_watchdog_nmi,
  output logic            wdt_nmi,
  output logic            ext_clock_select,
  output logic            main_osc_stop,
  output logic            xtal_out,
  output logic            xtal_oe_n
);
  localparam int CW = $clog2(POR_HOLD_CYC + 1) + 1;

  // Synchronised sources, bits: pin, supply ok, mon2..0, independent_watchdog, wdt, par, ecc, bm, bs, sp
  logic [11:0] src_raw;
  logic [11:0] src;
  assign src_raw = {ext_reset_n, supply_above_por, monitor_low, independent_watchdog_fault, wdt_fault,
                    sram_parity_err, sram_ecc_err, bus_master_mpu_err, bus_slave_mpu_err,
                    stack_ptr_err};

  mrsc_sync #(
    .WIDTH (12),
    .INIT  (12'h800)
  ) u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in (src_raw),
    .sync_out (src)
  );

  wire       pin_n     = src[11];
  wire       supply_ok = src[10];
  wire [2:0] mon       = src[9:7];
  wire       independent_watchdog_s    = src[6];
  wire       wdt_s     = src[5];
  wire       par_s     = src[4];
  wire       ecc_s     = src[3];
  wire       bmpu_s    = src[2];
  wire       bspu_s    = src[1];
  wire       sp_s      = src[0];

  logic [7:0]  status_first;
  logic [7:0]  status_second;
  logic [7:0]  status_third;
  logic [7:0]  control;
  logic [15:0] enable;
  mrsc_state_t state;
  mrsc_state_t next_state;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  // Enable bits: 0..2 monitors, 3 independent_watchdog reset (else nmi), 4 wdt reset (else nmi),
  // 5 parity, 6 ecc, 7 bus master, 8 bus slave, 9 stack pointer
  wire [2:0] mon_rst  = mon & enable[2:0];
  wire       independent_watchdog_rst = independent_watchdog_s & enable[3];
  wire       wdt_rst  = wdt_s & enable[4];
  wire       par_rst  = par_s & enable[5];
  wire       ecc_rst  = ecc_s & enable[6];
  wire       bmpu_rst = bmpu_s & enable[7];
  wire       bspu_rst = bspu_s & enable[8];
  wire       sp_rst   = sp_s & enable[9];

  assign independent_watchdog_nmi = independent_watchdog_s & ~enable[3];
  assign wdt_nmi  = wdt_s & ~enable[4];

  // Power-on is re-entered when supply drops with the pin high
  wire por_event = ~supply_ok & pin_n;
  wire pin_rst   = ~pin_n;
  wire sw_req    = wr && (addr == `MRSC_ADDR_CONTROL) && wdata[`MRSC_BIT_SWREQ];
  wire fault_any = |mon_rst | independent_watchdog_rst | wdt_rst | par_rst | ecc_rst |
                   bmpu_rst | bspu_rst | sp_rst;
  wire por_done  = (count >= CW'(POR_HOLD_CYC));
  wire sw_done   = (count >= CW'(SW_HOLD_CYC));

  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      MRSC_POR_HOLD: begin
        if (!supply_ok || !pin_n) begin
          next_count = '0;
        end else if (por_done) begin
          next_state = MRSC_RUN;
        end else begin
          next_count = count + CW'(1);
        end
      end
      MRSC_RUN: begin
        if (por_event) begin
          next_state = MRSC_POR_HOLD;
          next_count = '0;
        end else if (sw_req) begin
          next_state = MRSC_SW_HOLD;
          next_count = '0;
        end
      end
      MRSC_SW_HOLD: begin
        if (por_event) begin
          next_state = MRSC_POR_HOLD;
          next_count = '0;
        end else if (sw_done) begin
          next_state = MRSC_RUN;
        end else begin
          next_count = count + CW'(1);
        end
      end
      default: begin
        next_state = MRSC_POR_HOLD;
        next_count = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= MRSC_POR_HOLD;
      count <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // Internal reset: low while held, while pin low, or while any enabled fault stands
  assign sys_reset_n = (state == MRSC_RUN) && !pin_rst && !fault_any && !sw_req;

  wire in_por = (state == MRSC_POR_HOLD);

  // Write decode
  wire wr_ctrl = wr && (addr == `MRSC_ADDR_CONTROL);
  wire wr_en   = wr && (addr == `MRSC_ADDR_ENABLE);
  wire wr_st1  = wr && (addr == `MRSC_ADDR_STATUS_FIRST);
  wire wr_st2  = wr && (addr == `MRSC_ADDR_STATUS_SECOND);
  wire wr_st3  = wr && (addr == `MRSC_ADDR_STATUS_THIRD);

  // Hardware set wins over software write-zero-to-clear on the status bits
  wire [7:0] set_first  = {4'h0, mon_rst, 1'b0};
  wire [7:0] set_second = {sp_rst, bspu_rst, bmpu_rst, ecc_rst, par_rst,
                           (state == MRSC_RUN) && sw_req, wdt_rst, independent_watchdog_rst};

  // Status and control: power-on loads reset values; other resets leave them, but pin reset drops the power-on flag
  always_ff @(posedge clk) begin
    if (!nrst) begin
      status_first  <= 8'h01;
      status_second <= 8'h00;
      status_third  <= 8'h00;
      control       <= `MRSC_CONTROL_RESET;
      enable        <= `MRSC_ENABLE_RESET;
    end else if (in_por && !supply_ok) begin
      status_first  <= 8'h01;
      status_second <= 8'h00;
      status_third  <= 8'h00;
      control       <= `MRSC_CONTROL_RESET;
      enable        <= `MRSC_ENABLE_RESET;
    end else begin
      // Pin reset drops only the power-on flag; recorded causes stay
      status_first  <= ((wr_st1 ? (status_first & wdata) : status_first) | set_first)
                       & ~{7'h00, pin_rst};
      status_second <= (wr_st2 ? (status_second & wdata) : status_second) | set_second;
      if (wr_st3 && wdata[`MRSC_BIT_COLD_WARM_START_FLAG]) begin
        status_third[`MRSC_BIT_COLD_WARM_START_FLAG] <= 1'b1;
      end
      if (wr_ctrl) begin
        control <= {5'h00, 1'b0, wdata[`MRSC_BIT_OSCSTOP], wdata[`MRSC_BIT_EXTCLK]};
      end
      if (wr_en) begin
        enable <= {6'h00, wdata[1:0], enable[7:0]};
      end else if (wr && (addr == `MRSC_ADDR_LIVE)) begin
        enable <= {enable[15:8], wdata};
      end
    end
  end

  assign ext_clock_select = control[`MRSC_BIT_EXTCLK];
  assign main_osc_stop    = control[`MRSC_BIT_OSCSTOP];
  // Crystal drive floats when an external digital clock is selected
  assign xtal_oe_n = control[`MRSC_BIT_EXTCLK] | control[`MRSC_BIT_OSCSTOP];
  assign xtal_out  = 1'b0;

  // Read mux, registered one cycle later
  logic [7:0] rsel;
  wire [7:0] live = {pin_n, supply_ok, 1'b0, state == MRSC_RUN, mon, fault_any};
  always_comb begin
    case (addr)
      `MRSC_ADDR_STATUS_FIRST:  rsel = status_first;
      `MRSC_ADDR_STATUS_SECOND: rsel = status_second;
      `MRSC_ADDR_STATUS_THIRD:  rsel = status_third;
      `MRSC_ADDR_CONTROL:       rsel = control;
      `MRSC_ADDR_ENABLE:        rsel = {6'h00, enable[9:8]};
      `MRSC_ADDR_LIVE:          rsel = live;
      default:                  rsel = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? rsel : 8'h00;
    end
  end
endmodule // mrsc_reset_ctrl

// ---- verification/mrsc_reset_ctrl_asserts.sv ----
// Port assertions for the reset source controller.
// Assumes a bind from the bench with the same hold parameters.
`timescale 1ns/1ps
module mrsc_reset_ctrl_asserts #(
  parameter int POR_HOLD_CYC = 20,
  parameter int SW_HOLD_CYC  = 10
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       ext_reset_n,
  input wire logic       supply_above_por,
  input wire logic [2:0] monitor_low,
  input wire logic       independent_watchdog_fault,
  input wire logic       sram_ecc_err,
  input wire logic       bus_master_mpu_err,
  input wire logic       stack_ptr_err,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       sys_reset_n,
  input wire logic       independent_watchdog_nmi,
  input wire logic       ext_clock_select,
  input wire logic       main_osc_stop,
  input wire logic       xtal_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  int good_cnt;
  // Cycles the supply has stayed good, saturating past the hold time
  always_ff @(posedge clk) begin
    if (!nrst || !supply_above_por) good_cnt <= 0;
    else if (good_cnt <= POR_HOLD_CYC) good_cnt <= good_cnt + 1;
  end
  chk_pin_holds: assert property (!ext_reset_n [*6] |-> !sys_reset_n)
    else $error("pin held low but reset released");
  chk_wdog_reset: assert property (independent_watchdog_fault [*6] |-> !sys_reset_n || independent_watchdog_nmi)
    else $error("watchdog fault gave neither reset nor interrupt");
  chk_monitor_reset: assert property ((|monitor_low) [*6] |-> !sys_reset_n)
    else $error("low supply monitor without reset");
  chk_fault_reset: assert property (
    (sram_ecc_err || bus_master_mpu_err || stack_ptr_err) [*6] |-> !sys_reset_n)
    else $error("fault detector active without reset");
  chk_supply_low: assert property (!supply_above_por [*6] |-> !sys_reset_n)
    else $error("supply low without power-on reset");
  chk_por_hold: assert property ($rose(sys_reset_n) |-> good_cnt > POR_HOLD_CYC)
    else $error("reset released before the power-on hold ran out");
  chk_soft_hold: assert property (
    wr && addr == 4'h3 && wdata[2] |=> !sys_reset_n [*8] ##[1:40] sys_reset_n)
    else $error("software reset too short or never released");
  chk_xtal_float: assert property (xtal_oe_n == (ext_clock_select || main_osc_stop))
    else $error("crystal pin drive does not follow clock select");
endmodule // mrsc_reset_ctrl_asserts

// ---- verification/mrsc_fault_src.sv ----
// Model of the reset pin and the on-chip fault detectors.
// Assumes go pulses one cycle with a source index and a length.
`timescale 1ns/1ps
module mrsc_fault_src (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] sel,
  input  wire logic [7:0] len,
  output logic            ext_reset_n,
  output logic            supply_above_por,
  output logic      [2:0] monitor_low,
  output logic            independent_watchdog_fault,
  output logic            wdt_fault,
  output logic            sram_parity_err,
  output logic            sram_ecc_err,
  output logic            bus_master_mpu_err,
  output logic            bus_slave_mpu_err,
  output logic            stack_ptr_err
);
  logic [11:0] act = 12'h000;
  logic [7:0]  cnt = 8'h00;
  // One source active at a time, held for len cycles
  always @(posedge clk) begin
    if (go) begin
      act <= 12'h001 << sel;
      cnt <= len;
    end else if (cnt > 8'h01) cnt <= cnt - 8'h01;
    else act <= 12'h000;
  end
  // Pin has a pull-up, so it reads high when released
  assign ext_reset_n        = !act[0];
  assign supply_above_por   = !act[1];
  assign monitor_low        = act[4:2];
  assign independent_watchdog_fault         = act[5];
  assign wdt_fault          = act[6];
  assign sram_parity_err    = act[7];
  assign sram_ecc_err       = act[8];
  assign bus_master_mpu_err = act[9];
  assign bus_slave_mpu_err  = act[10];
  assign stack_ptr_err      = act[11];
endmodule // mrsc_fault_src

// ---- verification/mrsc_reset_ctrl_test.sv ----
// Self-checking bench for the reset source controller.
// Assumes the fault model and checker are compiled first.
`timescale 1ns/1ps
module mrsc_reset_ctrl_test;
  localparam int POR_HOLD_CYC = 20;
  localparam int SW_HOLD_CYC  = 10;
  logic       clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
  logic       rd_d = 1'b0, nmi_seen = 1'b0, wdt_seen = 1'b0, cw;
  logic [3:0] addr = 4'h0, sel = 4'h0;
  logic [7:0] wdata = 8'h00, len = 8'h00, rdata, ef, r;
  logic [2:0] monitor_low;
  logic ext_reset_n, supply_above_por, independent_watchdog_fault, wdt_fault, sram_parity_err;
  logic sram_ecc_err, bus_master_mpu_err, bus_slave_mpu_err, stack_ptr_err;
  logic sys_reset_n, independent_watchdog_nmi, wdt_nmi, ext_clock_select, main_osc_stop, xtal_out, xtal_oe_n;
  wire  [7:0] clk_pins = {4'h0, xtal_out, xtal_oe_n, main_osc_stop, ext_clock_select};
  logic [7:0] exp_q[$];
  string      name_q[$];
  int         fail_count = 0, n_compared = 0, cycles = 0;
  int         order [12] = '{2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 1, 0};
  logic [7:0] es_tab [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
                              8'h02, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};

  mrsc_fault_src u_far (.*);
  mrsc_reset_ctrl #(.POR_HOLD_CYC(POR_HOLD_CYC), .SW_HOLD_CYC(SW_HOLD_CYC)) uut (.*);

  // Core clock far above the flash-operation minimum
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic check(string n, logic [7:0] e, logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Read data stand one cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) check(name_q.pop_front(), exp_q.pop_front(), rdata);
    rd_d <= rd;
    if (independent_watchdog_nmi === 1'b1) nmi_seen <= 1'b1;
    if (wdt_nmi === 1'b1) wdt_seen <= 1'b1;
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(string n, logic [3:0] a, logic [7:0] e);
    exp_q.push_back(e);
    name_q.push_back(n);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_rst(logic v, int lim);
    for (int k = 0; k < lim && sys_reset_n !== v; k++) @(posedge clk) #1;
    check("sys_reset_n", {7'h00, v}, {7'h00, sys_reset_n});
    @(posedge clk);
  endtask

  task automatic fire(logic [3:0] s);
    sel <= s;
    len <= 8'h08 + 8'($urandom % 8);
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
  endtask

  initial begin
    void'($urandom(32'hc849_0b52));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    wait_rst(1'b1, 100);
    rd_reg("status_first", 4'h0, 8'h01);
    rd_reg("control", 4'h3, 8'h02);
    cw = 1'b0;
    repeat (4) begin
      r = 8'($urandom);
      cw = cw | r[0];
      wr_reg(4'h2, r);
      rd_reg("status_third", 4'h2, {7'h00, cw});
    end
    wr_reg(4'h2, 8'h01);
    wr_reg(4'h0, 8'h00);
    ef = 8'h00;
    foreach (order[i]) begin
      wr_reg(4'h1, 8'h00);
      fire(4'(order[i]));
      wait_rst(1'b0, 20);
      wait_rst(1'b1, 100);
      if (order[i] inside {[2:4]}) ef[order[i] - 1] = 1'b1;
      if (order[i] == 1) ef = 8'h01;
      if (order[i] == 0) ef[0] = 1'b0;
      rd_reg("status_first", 4'h0, ef);
      rd_reg("status_second", 4'h1, es_tab[order[i]]);
      if (order[i] == 1) rd_reg("status_third", 4'h2, 8'h00);
    end
    wr_reg(4'h5, 8'hE7);
    fire(4'h5);
    repeat (30) @(posedge clk);
    fire(4'h6);
    repeat (30) @(posedge clk);
    check("wdog_nmi", 8'h03, {6'h00, wdt_seen, nmi_seen});
    rd_reg("enable_high", 4'h4, 8'h03);
    wr_reg(4'h4, 8'h00);
    fire(4'hA);
    repeat (30) @(posedge clk);
    rd_reg("status_second", 4'h1, 8'h00);
    wr_reg(4'h4, 8'h03);
    wr_reg(4'h5, 8'hFF);
    check("clock_pins", 8'h06, clk_pins);
    wr_reg(4'h3, 8'h03);
    check("clock_pins", 8'h07, clk_pins);
    rd_reg("control", 4'h3, 8'h03);
    wr_reg(4'h3, 8'h01);
    check("clock_pins", 8'h05, clk_pins);
    rd_reg("control", 4'h3, 8'h01);
    wr_reg(4'h3, 8'h04);
    wait_rst(1'b0, 4);
    wait_rst(1'b1, 40);
    check("clock_pins", 8'h00, clk_pins);
    rd_reg("status_second", 4'h1, 8'h04);
    rd_reg("control", 4'h3, 8'h00);
    wr_reg(4'hE, 8'($urandom));
    rd_reg("unmapped", 4'hF, 8'h00);
    rd_reg("status_first", 4'h0, ef);
    repeat (2) @(posedge clk);
    check("reads_pending", 8'h00, 8'(exp_q.size()));
    finish_test();
  end
endmodule // mrsc_reset_ctrl_test

bind mrsc_reset_ctrl mrsc_reset_ctrl_asserts #(
  .POR_HOLD_CYC(POR_HOLD_CYC),
  .SW_HOLD_CYC(SW_HOLD_CYC)
) u_chk (.*);
